// ### design/acp_pkg.sv
/*
 * constants, field positions, reset values and states of the serial command port
 * assumes a single 50 MHz core clock; link pins are asynchronous to it
 */
package acp_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int WAKE_MS = 20;
	localparam int WAKE_CYCLES = (CLK_HZ / 1000) * WAKE_MS;
	localparam int WAKE_W = 20;

	localparam int CMD_BITS = 8;
	localparam int WORD_BITS = 32;
	localparam int NUM_SETUP_REGS = 4;
	localparam int RESYNC_ONES = 15;

	localparam int CMD_TYPE_BIT = 7;
	localparam int ARRAY_BIT = 6;
	localparam int REPEAT_BIT = 6;
	localparam int CH_HI = 5;
	localparam int CH_LO = 4;
	localparam int DIR_BIT = 3;
	localparam int PTR_HI = 5;
	localparam int PTR_LO = 3;

	localparam logic [2:0] SEL_RESULT = 3'h0;
	localparam logic [2:0] SEL_OFFSET = 3'h1;
	localparam logic [2:0] SEL_GAIN = 3'h2;
	localparam logic [2:0] SEL_CONFIG = 3'h3;
	localparam logic [2:0] SEL_SETUP = 3'h5;

	localparam logic [2:0] CODE_CONV = 3'h0;
	localparam logic [2:0] CODE_SELF_OFF = 3'h1;
	localparam logic [2:0] CODE_SELF_GAIN = 3'h2;
	localparam logic [2:0] CODE_SYS_OFF = 3'h5;
	localparam logic [2:0] CODE_SYS_GAIN = 3'h6;

	localparam logic [7:0] NULL_BYTE = 8'h00;
	localparam logic [7:0] FILL_BYTE = 8'hff;
	localparam logic [7:0] END_BYTE = 8'hfe;

	localparam int CFG_KIND = 31;
	localparam int CFG_PDOWN = 30;
	localparam int CFG_RESET = 29;
	localparam int CFG_DONE = 28;
	localparam int CFG_SHORT = 27;
	localparam logic [31:0] CFG_WR_MASK = 32'hefd80000;

	localparam logic [31:0] RST_CFG = 32'h00000000;
	localparam logic [31:0] RST_OFFSET = 32'h00000000;
	localparam logic [31:0] RST_GAIN = 32'h01000000;
	localparam logic [31:0] RST_SETUP = 32'h00000000;

	typedef enum logic [1:0] {
		ST_CMD = 2'b00,
		ST_WR = 2'b01,
		ST_RD = 2'b10
	} acp_state_t;
endpackage

// ### design/acp_port.sv
/*
 * serial command port: command decode, register file, power and soft reset
 * assumes host drives chip select, bit clock and data; link pins and external clock are resampled
 */
module acp_port
	import acp_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter int WAKE_CYCLES_P = WAKE_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic chip_sel_n_i,
	input wire logic bit_clk_i,
	input wire logic serial_in_line_i,
	input wire logic ext_clock_i,
	input wire logic conv_done_i,
	input wire logic [31:0] conv_data_i,
	output logic serial_out_line_o,
	output logic serial_out_line_oe_o,
	output logic conv_start_o,
	output logic repeat_conversion_flag_o,
	output logic [2:0] setup_pointer_o,
	output logic cal_start_o,
	output logic [2:0] calibration_code_o,
	output logic conv_active_o,
	output logic port_flag_o,
	output logic [31:0] setup_word_o,
	output logic logic_reset_o,
	output logic standby_o,
	output logic sleep_o,
	output logic filter_run_o,
	output logic input_short_flag_o
);

	// ***********************
	// elaboration checks
	// ***********************
	if (CHANNELS != 2 && CHANNELS != 4) begin : g_ch_chk
		$error("CHANNELS must be 2 or 4");
	end
	if (WAKE_CYCLES_P < 1 || WAKE_CYCLES_P >= 2 ** WAKE_W) begin : g_wake_chk
		$error("WAKE_CYCLES_P out of range");
	end

	// ***********************
	// state
	// ***********************
	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic ck_m;
		logic ck_s;
		logic ck_d;
		logic di_m;
		logic di_s;
		logic ext_m;
		logic ext_s;
		acp_state_t st;
		logic [4:0] bitcnt;
		logic [4:0] ones;
		logic [31:0] shin;
		logic [31:0] shout;
		logic arr;
		logic [2:0] sel;
		logic [1:0] idx;
		logic [3:0][31:0] off;
		logic [3:0][31:0] gain;
		logic [3:0][31:0] setup;
		logic [31:0] cfg;
		logic [31:0] result;
		logic rpt;
		logic active;
		logic flag;
		logic conv_start;
		logic cal_start;
		logic logic_reset;
		logic [2:0] ptr;
		logic [2:0] cal_code;
		logic [WAKE_W-1:0] wake;
		logic was_sleep;
		logic standby;
		logic sleep;
		logic run;
		logic out_oe;
		logic [31:0] setup_word;
	} acp_regs_t;

	localparam acp_regs_t RST_S = '{
		cs_m: 1'b1,
		cs_s: 1'b1,
		st: ST_CMD,
		gain: {4{RST_GAIN}},
		default: '0
	};

	acp_regs_t s;
	acp_regs_t n;

	function automatic logic [31:0] rd_word(acp_regs_t r, logic [2:0] sel, logic [1:0] i);
		logic [31:0] w;
		w = '0;
		case (sel)
			SEL_OFFSET: w = r.off[i];
			SEL_GAIN: w = r.gain[i];
			SEL_CONFIG: w = r.cfg;
			SEL_SETUP: w = r.setup[i];
			SEL_RESULT: w = r.result;
			default: w = '0;
		endcase
		return w;
	endfunction

	// ***********************
	// next state
	// ***********************
	logic rise;
	logic [7:0] cbyte;
	logic [31:0] word;
	logic [1:0] last;
	logic sel_ok;

	always_comb begin
		n = s;
		rise = 1'b0;
		cbyte = {s.shin[6:0], s.di_s};
		word = {s.shin[30:0], s.di_s};
		last = (s.sel == SEL_SETUP) ? 2'(NUM_SETUP_REGS - 1) : 2'(CHANNELS - 1);
		sel_ok = 1'b0;
		n.conv_start = 1'b0;
		n.cal_start = 1'b0;
		n.logic_reset = 1'b0;

		// pin resampling
		n.cs_m = chip_sel_n_i;
		n.cs_s = s.cs_m;
		n.ck_m = bit_clk_i;
		n.ck_s = s.ck_m;
		n.ck_d = s.ck_s;
		n.di_m = serial_in_line_i;
		n.di_s = s.di_m;
		n.ext_m = ext_clock_i;
		n.ext_s = s.ext_m;

		rise = s.ck_s & ~s.ck_d & ~s.cs_s;
		n.out_oe = ~s.cs_s;

		// conversion results from the filter
		if (conv_done_i) begin
			n.result = conv_data_i;
			n.flag = 1'b1;
			if (!s.rpt) begin
				n.active = 1'b0;
			end
		end

		if (rise) begin
			n.ones = s.di_s ? ((s.ones == 5'h1f) ? s.ones : s.ones + 5'h01) : 5'h00;
			n.shin = word;
			n.bitcnt = s.bitcnt + 5'h01;
			if (!s.di_s && s.ones >= 5'(RESYNC_ONES)) begin
				n.st = ST_CMD;
				n.bitcnt = '0;
				n.arr = 1'b0;
			end else begin
				case (s.st)
					ST_CMD: begin
						if (s.bitcnt == 5'(CMD_BITS - 1)) begin
							n.bitcnt = '0;
							if (!cbyte[CMD_TYPE_BIT]) begin
								if (cbyte == NULL_BYTE) begin
									if (!conv_done_i) begin
										n.flag = 1'b0;
									end
								end else begin
									sel_ok = (cbyte[2:0] == SEL_OFFSET) || (cbyte[2:0] == SEL_GAIN) ||
										(cbyte[2:0] == SEL_CONFIG) || (cbyte[2:0] == SEL_SETUP) ||
										(cbyte[2:0] == SEL_RESULT);
									if (sel_ok) begin
										n.sel = cbyte[2:0];
										n.arr = cbyte[ARRAY_BIT] && (cbyte[2:0] != SEL_CONFIG) &&
											(cbyte[2:0] != SEL_RESULT);
										n.idx = n.arr ? 2'h0 : cbyte[CH_HI:CH_LO];
										if (cbyte[DIR_BIT]) begin
											n.st = ST_RD;
											n.shout = rd_word(s, n.sel, n.idx);
											if (n.sel == SEL_CONFIG) begin
												n.cfg[CFG_DONE] = 1'b0;
											end
										end else if (n.sel != SEL_RESULT) begin
											n.st = ST_WR;
										end
									end
								end
							end else if (cbyte != FILL_BYTE && cbyte != END_BYTE) begin
								if (cbyte[2:0] == CODE_CONV) begin
									n.conv_start = 1'b1;
									n.rpt = cbyte[REPEAT_BIT];
									n.ptr = cbyte[PTR_HI:PTR_LO];
									n.active = 1'b1;
								end else if (!cbyte[REPEAT_BIT] && ((cbyte[2:0] == CODE_SELF_OFF) ||
									(cbyte[2:0] == CODE_SELF_GAIN) || (cbyte[2:0] == CODE_SYS_OFF) ||
									(cbyte[2:0] == CODE_SYS_GAIN))) begin
									n.cal_start = 1'b1;
									n.cal_code = cbyte[2:0];
									n.ptr = cbyte[PTR_HI:PTR_LO];
								end
							end
						end
					end
					ST_WR: begin
						if (s.bitcnt == 5'(WORD_BITS - 1)) begin
							n.bitcnt = '0;
							case (s.sel)
								SEL_OFFSET: n.off[s.idx] = word;
								SEL_GAIN: n.gain[s.idx] = word;
								SEL_SETUP: n.setup[s.idx] = word;
								SEL_CONFIG: begin
									if (word[CFG_RESET]) begin
										for (int i = 0; i < NUM_SETUP_REGS; i++) begin
											n.off[i] = RST_OFFSET;
											n.gain[i] = RST_GAIN;
											n.setup[i] = RST_SETUP;
										end
										n.cfg = RST_CFG;
										n.cfg[CFG_RESET] = 1'b1;
										n.cfg[CFG_DONE] = 1'b1;
										n.active = 1'b0;
										n.rpt = 1'b0;
										n.logic_reset = 1'b1;
									end else begin
										n.cfg = (word & CFG_WR_MASK) | (s.cfg & ~CFG_WR_MASK);
									end
								end
								default: n.st = ST_CMD;
							endcase
							if (s.arr && s.idx != last) begin
								n.idx = s.idx + 2'h1;
							end else begin
								n.st = ST_CMD;
								n.arr = 1'b0;
							end
						end
					end
					ST_RD: begin
						n.shout = {s.shout[30:0], 1'b0};
						if (s.bitcnt == 5'(WORD_BITS - 1)) begin
							n.bitcnt = '0;
							if (s.arr && s.idx != last) begin
								n.idx = s.idx + 2'h1;
								n.shout = rd_word(s, s.sel, s.idx + 2'h1);
							end else begin
								n.st = ST_CMD;
								n.arr = 1'b0;
							end
						end
					end
					default: begin
						n.st = ST_CMD;
						n.bitcnt = '0;
					end
				endcase
			end
		end

		// power save and oscillator restart
		n.was_sleep = s.cfg[CFG_PDOWN] & s.cfg[CFG_KIND];
		if (s.was_sleep && !(n.cfg[CFG_PDOWN] && n.cfg[CFG_KIND]) && !s.ext_s) begin
			n.wake = WAKE_W'(WAKE_CYCLES_P);
		end else if (s.wake != '0) begin
			n.wake = s.wake - WAKE_W'(1);
		end
		n.standby = n.cfg[CFG_PDOWN] & ~n.cfg[CFG_KIND];
		n.sleep = n.cfg[CFG_PDOWN] & n.cfg[CFG_KIND];
		n.run = ~n.cfg[CFG_PDOWN] & (n.wake == '0) & ~n.cfg[CFG_RESET];
		n.setup_word = n.setup[n.ptr[2:1]];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= RST_S;
		end else begin
			s <= n;
		end
	end

	// ***********************
	// outputs
	// ***********************
	assign serial_out_line_o = s.shout[31];
	assign serial_out_line_oe_o = s.out_oe;
	assign conv_start_o = s.conv_start;
	assign repeat_conversion_flag_o = s.rpt;
	assign setup_pointer_o = s.ptr;
	assign cal_start_o = s.cal_start;
	assign calibration_code_o = s.cal_code;
	assign conv_active_o = s.active;
	assign port_flag_o = s.flag;
	assign setup_word_o = s.setup_word;
	assign logic_reset_o = s.logic_reset;
	assign standby_o = s.standby;
	assign sleep_o = s.sleep;
	assign filter_run_o = s.run;
	assign input_short_flag_o = s.cfg[CFG_SHORT];

endmodule

// ### dv/acp_port_monitor.sv
/* checker watching the ports of the serial command port
   assumes it is bound into acp_port and shares its wake parameter */
module acp_port_monitor
	import acp_pkg::*;
#(
	parameter int WAKE_CYCLES_P = 50
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic chip_sel_n_i,
	input wire logic ext_clock_i,
	input wire logic conv_done_i,
	input wire logic serial_out_line_oe_o,
	input wire logic conv_start_o,
	input wire logic cal_start_o,
	input wire logic [2:0] calibration_code_o,
	input wire logic conv_active_o,
	input wire logic port_flag_o,
	input wire logic [31:0] setup_word_o,
	input wire logic logic_reset_o,
	input wire logic standby_o,
	input wire logic sleep_o,
	input wire logic filter_run_o,
	input wire logic input_short_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ***
	// cycles since leaving sleep
	// ***
	int unsigned wake_r;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			wake_r <= 0;
		else if ($fell(sleep_o) && !ext_clock_i)
			wake_r <= 1;
		else if (wake_r != 0 && wake_r <= WAKE_CYCLES_P)
			wake_r <= wake_r + 1;
	end
	a_oe_released: assert property (chip_sel_n_i [*4] |-> !serial_out_line_oe_o)
		else $error("output enabled while deselected");
	a_flag_set: assert property (conv_done_i |=> port_flag_o)
		else $error("port flag not set by result");
	a_power_halts: assert property (standby_o || sleep_o |-> !filter_run_o)
		else $error("filter runs in power save");
	a_wake_wait: assert property (filter_run_o && wake_r != 0 |-> wake_r >= WAKE_CYCLES_P - 2)
		else $error("filter ran before wake wait ended");
	a_reset_clears: assert property (logic_reset_o |-> ##[0:2] (setup_word_o == RST_SETUP && !conv_active_o))
		else $error("soft reset left state behind");
	a_reset_only: assert property (logic_reset_o |-> ##[0:2] (!input_short_flag_o && !standby_o))
		else $error("soft reset write set other bits");
	a_start_runs: assert property (conv_start_o |-> ##[0:1] conv_active_o)
		else $error("conversion start without activity");
	a_cal_code: assert property (cal_start_o |-> ##[0:1] (^calibration_code_o[1:0]))
		else $error("calibration started on reserved code");
endmodule

bind acp_port acp_port_monitor #(.WAKE_CYCLES_P(WAKE_CYCLES_P)) i_mon (.*);

// ### dv/acp_host_model.sv
/* host side of the serial link: chip select, bit clock and data
   assumes a 50 MHz core clock, giving a 160 ns bit clock */
module acp_host_model (
	input wire logic clk_i,
	input wire logic serial_out_line_i,
	input wire logic serial_out_line_oe_i,
	output logic chip_sel_n_o,
	output logic bit_clk_o,
	output logic serial_in_line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		chip_sel_n_o = 1'b1;
		bit_clk_o = 1'b0;
		serial_in_line_o = 1'b1;
	end
	// ***
	// link tasks
	// ***
	task automatic select(input logic n);
		@(posedge clk_i);
		chip_sel_n_o <= n;
		repeat (4) @(posedge clk_i);
	endtask
	// top n bits of d, msb first; bit clock stands low outside frames
	task automatic shift(input logic [31:0] d, input int n, output logic [31:0] q);
		q = '0;
		@(posedge clk_i);
		for (int i = 31; i > 31 - n; i--) begin
			serial_in_line_o <= d[i];
			repeat (4) @(posedge clk_i);
			q = {q[30:0], serial_out_line_oe_i ? serial_out_line_i : 1'bx};
			bit_clk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			bit_clk_o <= 1'b0;
		end
		serial_in_line_o <= ~d[32 - n];
	endtask
endmodule

// ### dv/testbench.sv
/* self-checking bench for the serial command port
   assumes the port, its checker and the host model are compiled first */
module testbench
	import acp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WAKE = 50;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic done = 1'b0;
	logic [31:0] data = '0;
	logic cs_n, bclk, din, dout, oe, start, rpt, cal, act, flag, lrst, stby, slp, run, shrt;
	logic [2:0] ptr, code;
	logic [31:0] sw, q;
	int failures, checks_done, n_conv, n_cal, n_rst;
	always #10 clk = ~clk;
	always @(posedge clk) begin
		n_conv += start;
		n_cal += cal;
		n_rst += lrst;
	end
	acp_port #(.CHANNELS(4), .WAKE_CYCLES_P(WAKE)) i_dut (.clk_i(clk), .rst_n_i(rst_n),
		.chip_sel_n_i(cs_n), .bit_clk_i(bclk), .serial_in_line_i(din), .ext_clock_i(1'b0),
		.conv_done_i(done), .conv_data_i(data), .serial_out_line_o(dout),
		.serial_out_line_oe_o(oe), .conv_start_o(start), .repeat_conversion_flag_o(rpt),
		.setup_pointer_o(ptr), .cal_start_o(cal), .calibration_code_o(code),
		.conv_active_o(act), .port_flag_o(flag), .setup_word_o(sw), .logic_reset_o(lrst),
		.standby_o(stby), .sleep_o(slp), .filter_run_o(run), .input_short_flag_o(shrt));
	acp_host_model i_host (.clk_i(clk), .serial_out_line_i(dout), .serial_out_line_oe_i(oe),
		.chip_sel_n_o(cs_n), .bit_clk_o(bclk), .serial_in_line_o(din));
	// ***
	// helpers
	// ***
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		i_host.shift({c, 24'h0}, 8, q);
		repeat (4) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] c, input logic [31:0] d);
		cmd(c);
		i_host.shift(d, 32, q);
		repeat (4) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] c, input logic [31:0] exp);
		cmd(c);
		i_host.shift(32'h0, 32, q);
		check($sformatf("read %h", c), exp, q);
	endtask
	task automatic pulse(input logic [31:0] d);
		@(posedge clk);
		done <= 1'b1;
		data <= d;
		@(posedge clk);
		done <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ***
	// scenarios
	// ***
	task automatic t_regs();
		rd(8'h0a, RST_GAIN);
		rd(8'h39, RST_OFFSET);
		rd(8'h0d, RST_SETUP);
		rd(8'h0b, RST_CFG);
		wr(8'h02, 32'h80000000);
		rd(8'h0a, 32'h80000000);
		rd(8'h1a, RST_GAIN);
	endtask
	task automatic t_array();
		cmd(8'h42);
		for (int k = 1; k <= 4; k++)
			i_host.shift(32'h11111111 * k, 32, q);
		repeat (4) @(posedge clk);
		for (int k = 0; k < 4; k++)
			rd({2'b00, k[1:0], 4'ha}, 32'h11111111 * (k + 1));
		cmd(8'h4a);
		for (int k = 1; k <= 4; k++) begin
			i_host.shift(32'h0, 32, q);
			check("array word", 32'h11111111 * k, q);
		end
	endtask
	task automatic t_conv();
		wr(8'h05, 32'h12345678);
		cmd(8'hc8);
		check("repeat", 1, rpt);
		check("setup word", 32'h12345678, sw);
		cmd(8'hb8);
		check("pointer", 7, ptr);
		check("starts", 2, n_conv);
		pulse(32'ha5c3f00f);
		check("single stops", 0, act);
		rd(8'h08, 32'ha5c3f00f);
		cmd(8'hc0);
		pulse(32'h0);
		cmd(8'h00);
		check("flag", 0, flag);
		check("running", 1, act);
	endtask
	task automatic t_cal();
		int exp_cal;
		exp_cal = n_cal;
		for (int c = 1; c < 8; c++) begin
			cmd({5'b10010, c[2:0]});
			exp_cal += c[1] ^ c[0];
			check("cal starts", exp_cal, n_cal);
			if (c[1] ^ c[0])
				check("cal code", c, code);
		end
	endtask
	task automatic t_link();
		i_host.select(1'b1);
		check("output enable", 0, oe);
		wr(8'h02, 32'hdeadbeef);
		i_host.select(1'b0);
		rd(8'h0a, 32'h11111111);
		cmd(8'h02);
		i_host.shift(32'h12340000, 16, q);
		cmd(8'hff);
		cmd(8'hfe);
		rd(8'h0a, 32'h11111111);
	endtask
	task automatic t_cfg();
		wr(8'h03, 32'h08000000);
		check("input short", 1, shrt);
		wr(8'h03, 32'h40000000);
		check("standby", 1, stby);
		wr(8'h03, 32'hc0000000);
		check("sleep", 1, slp);
		wr(8'h03, 32'h00000000);
		check("waking", 0, run);
		repeat (WAKE + 10) @(posedge clk);
		check("filter", 1, run);
		wr(8'h03, 32'h28000000);
		check("soft resets", 1, n_rst);
		check("input short", 0, shrt);
		rd(8'h0a, RST_GAIN);
		rd(8'h0b, 32'h30000000);
		rd(8'h0b, 32'h20000000);
		wr(8'h03, 32'h00000000);
		rd(8'h0b, RST_CFG);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		i_host.select(1'b0);
		t_regs();
		t_array();
		t_conv();
		t_cal();
		t_link();
		t_cfg();
		give_verdict();
	end
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule
